/* hdl/boundary_scan_test_registers.v */
`timescale 1ns/1ps
`default_nettype none
`include "bscan_consts.vh"

// What this block does
// RL1: one-bit bypass stage links serial in to out for bypass, clamp, high-z.
// RL2: boundary chain has shift stages plus separately latched update stages per cell.
// RL3: identification register is a 32-bit shift stage plus 32-bit latch.
// RL4: identification register selected under idcode and in test-logic-reset.
// RL5: cell 0 control enables cell 1 frame pulse output; pairing repeats per port.
// RL6: frame pulse pin has observe cell right after its output cell.
// RL7: transmit serial data output cells are enabled by shared control cell 161.
// RL8: receive frame pulse, clock, data observe cells, per port, descending port order.
// RL9: delineation-lost outputs at cells 54..69 descending, enabled by cell 161.
// RL10: cell bus parity and start-of-cell outputs enabled by control cell 77.
// RL11: cell-available bits 3..1 enabled by cell 73, bit 0 by cell 75.
// RL12: eight cell bus byte outputs share enable of control cell 86.
// RL13: selected register shifts one stage toward serial out per rising test clock.
// RL14: identification value: lsb 1, 11 maker, 16 device, 4 version bits.
// RL15: observe cells capture pin in capture-dr and never drive the pin.
module boundary_scan_test_registers (
    // system
    input  wire        SYS_CLK,
    input  wire        SYS_RST,
    // test link from the tap controller
    input  wire        TEST_CLOCK,
    input  wire        TEST_SERIAL_IN,
    input  wire        TEST_LOGIC_RESET,
    input  wire        TEST_CAPTURE_DR,
    input  wire        TEST_SHIFT_DR,
    input  wire        TEST_UPDATE_DR,
    input  wire [2:0]  TEST_INSTR,
    output reg         TEST_SERIAL_OUT,
    output reg  [31:0] TEST_ID_LATCH,
    // transmit line pins, index is port minus 4
    input  wire [9:0]  TX_FRAME_PULSE_PORT_IN,
    output reg  [9:0]  TX_FRAME_PULSE_PORT_OUT,
    output reg  [9:0]  TX_FRAME_PULSE_PORT_OE_N,
    input  wire [9:0]  TX_LINE_CLOCK_PORT,
    output reg  [9:0]  TX_SERIAL_DATA_PORT_OUT,
    output reg  [9:0]  TX_SERIAL_DATA_PORT_OE_N,
    // receive line pins, index is port minus 8
    input  wire [7:0]  RX_FRAME_PULSE_PORT,
    input  wire [7:0]  RX_LINE_CLOCK_PORT,
    input  wire [7:0]  RX_SERIAL_DATA_PORT,
    output reg  [15:0] RX_DELINEATION_LOST_PORT_OUT,
    output reg  [15:0] RX_DELINEATION_LOST_PORT_OE_N,
    // cell bus pins
    output reg         CELLBUS_RX_PARITY_OUT,
    output reg         CELLBUS_RX_PARITY_OE_N,
    output reg         CELLBUS_RX_START_OF_CELL_OUT,
    output reg         CELLBUS_RX_START_OF_CELL_OE_N,
    output reg  [3:0]  CELLBUS_RX_CELL_AVAIL_OUT,
    output reg  [3:0]  CELLBUS_RX_CELL_AVAIL_OE_N,
    output reg  [7:0]  CELLBUS_RX_BYTE_OUT,
    output reg  [7:0]  CELLBUS_RX_BYTE_OE_N,
    input  wire [33:0] CELLBUS_AUX_IN,
    // core side, system-mode values
    input  wire [9:0]  CORE_TX_FRAME_PULSE,
    input  wire [9:0]  CORE_TX_FRAME_PULSE_OE_N,
    input  wire [9:0]  CORE_TX_SERIAL_DATA,
    input  wire [15:0] CORE_DELINEATION_LOST,
    input  wire        CORE_CELLBUS_PARITY,
    input  wire        CORE_CELLBUS_START_OF_CELL,
    input  wire [3:0]  CORE_CELLBUS_CELL_AVAIL,
    input  wire [7:0]  CORE_CELLBUS_BYTE,
    input  wire        CORE_OUTPUT_OE_N
);

    // ==========================================================
    // input synchronisers
    localparam SW = 87;
    wire [SW-1:0] async_in = {CELLBUS_AUX_IN, RX_SERIAL_DATA_PORT, RX_LINE_CLOCK_PORT,
                              RX_FRAME_PULSE_PORT, TX_LINE_CLOCK_PORT, TX_FRAME_PULSE_PORT_IN,
                              TEST_INSTR, TEST_UPDATE_DR, TEST_SHIFT_DR, TEST_CAPTURE_DR,
                              TEST_LOGIC_RESET, TEST_SERIAL_IN, TEST_CLOCK};
    reg  [SW-1:0] sync1_reg;
    reg  [SW-1:0] sync2_reg;
    reg           tck_d_reg;

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync1_reg <= {SW{1'b0}};
            sync2_reg <= {SW{1'b0}};
            tck_d_reg <= 1'b0;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
            tck_d_reg <= sync2_reg[0];
        end
    end

    wire        tck_s    = sync2_reg[0];
    wire        tdi_s    = sync2_reg[1];
    wire        tlr_s    = sync2_reg[2];
    wire        cap_s    = sync2_reg[3];
    wire        shf_s    = sync2_reg[4];
    wire        upd_s    = sync2_reg[5];
    wire [2:0]  ins_s    = sync2_reg[8:6];
    wire [9:0]  fp_in_s  = sync2_reg[18:9];
    wire [9:0]  tclk_s   = sync2_reg[28:19];
    wire [7:0]  rfp_s    = sync2_reg[36:29];
    wire [7:0]  rclk_s   = sync2_reg[44:37];
    wire [7:0]  rdat_s   = sync2_reg[52:45];
    wire [33:0] aux_s    = sync2_reg[86:53];
    wire        tck_rise = tck_s & ~tck_d_reg;
    wire        tck_fall = ~tck_s & tck_d_reg;

    // ==========================================================
    // register selection and output modes
    wire sel_id  = tlr_s | (ins_s == `INS_IDCODE);                               // [RL4]
    wire sel_bsr = ~tlr_s & ((ins_s == `INS_EXTEST) | (ins_s == `INS_SAMPLE));
    wire sel_byp = ~sel_id & ~sel_bsr;                                           // [RL1]
    wire bs_drive = ~tlr_s & ((ins_s == `INS_EXTEST) | (ins_s == `INS_CLAMP));
    wire bs_highz = ~tlr_s & (ins_s == `INS_HIGHZ);

    // ==========================================================
    // test data registers
    reg [`BSR_LEN-1:0] bsr_reg;
    reg [`BSR_LEN-1:0] upd_reg;
    reg [`BSR_LEN-1:0] cap_next;
    reg [31:0]         id_reg;
    reg                byp_reg;

    // capture values; controls and spare cells keep their update value
    integer i;
    integer c;
    always @* begin
        cap_next = upd_reg;
        c = 0;
        for (i = 0; i < 10; i = i + 1) begin
            c = (i >= 4) ? `TX_HI_BASE + (9 - i) * `TX_CELLS : `TX_LO_BASE + (3 - i) * `TX_CELLS;
            cap_next[c + 1] = CORE_TX_FRAME_PULSE[i];
            cap_next[c + 2] = fp_in_s[i];                                         // [RL6] [RL15]
            cap_next[c + 3] = tclk_s[i];                                          // [RL15]
            cap_next[c + 4] = CORE_TX_SERIAL_DATA[i];
        end
        for (i = 0; i < 8; i = i + 1) begin
            c = `RX_BASE + (7 - i) * `RX_CELLS;
            cap_next[c]     = rfp_s[i];                                           // [RL8] [RL15]
            cap_next[c + 1] = rclk_s[i];                                          // [RL8]
            cap_next[c + 2] = rdat_s[i];                                          // [RL8]
        end
        for (i = 0; i < 16; i = i + 1) begin
            cap_next[`LCD_BASE + 15 - i] = CORE_DELINEATION_LOST[i];
        end
        cap_next[`CB_PARITY_CELL] = CORE_CELLBUS_PARITY;
        cap_next[`CB_SOC_CELL]    = CORE_CELLBUS_START_OF_CELL;
        cap_next[`CB_CLAV3_CELL]  = CORE_CELLBUS_CELL_AVAIL[3];
        cap_next[`CB_CLAV2_CELL]  = CORE_CELLBUS_CELL_AVAIL[2];
        cap_next[`CB_CLAV1_CELL]  = CORE_CELLBUS_CELL_AVAIL[1];
        cap_next[`CB_CLAV0_CELL]  = CORE_CELLBUS_CELL_AVAIL[0];
        for (i = 0; i < 7; i = i + 1) begin
            cap_next[`CB_BYTE_BASE + i] = CORE_CELLBUS_BYTE[i];
        end
        cap_next[`CB_BYTE7_CELL] = CORE_CELLBUS_BYTE[7];
        for (i = 0; i < `AUX_LEN; i = i + 1) begin
            cap_next[`AUX_BASE + i] = aux_s[i];                                   // [RL15]
        end
    end

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bsr_reg         <= {`BSR_LEN{1'b0}};
            upd_reg         <= {`BSR_LEN{1'b0}};
            id_reg          <= `ID_VALUE;
            TEST_ID_LATCH   <= `ID_VALUE;
            byp_reg         <= 1'b0;
            TEST_SERIAL_OUT <= 1'b0;
        end else begin
            if (tck_rise) begin
                if (tlr_s) begin
                    id_reg <= `ID_VALUE;                                          // [RL4] [RL14]
                end else if (cap_s) begin
                    if (sel_id)
                        id_reg <= `ID_VALUE;                                      // [RL14]
                    else if (sel_bsr)
                        bsr_reg <= cap_next;
                    else
                        byp_reg <= 1'b0;
                end else if (shf_s) begin
                    if (sel_id)
                        id_reg <= {tdi_s, id_reg[31:1]};                          // [RL3] [RL13]
                    else if (sel_bsr)
                        bsr_reg <= {tdi_s, bsr_reg[`BSR_LEN-1:1]};                // [RL2] [RL13]
                    else
                        byp_reg <= tdi_s;                                         // [RL1] [RL13]
                end
            end
            if (tck_fall && upd_s && !tlr_s) begin
                if (sel_bsr)
                    upd_reg <= bsr_reg;                                           // [RL2]
                if (sel_id)
                    TEST_ID_LATCH <= id_reg;                                      // [RL3]
            end
            TEST_SERIAL_OUT <= sel_id ? id_reg[0] : (sel_bsr ? bsr_reg[0] : byp_reg);
        end
    end

    // ==========================================================
    // pin drive: core values, or update latches under extest/clamp
    wire [9:0]  fp_o;
    wire [9:0]  fp_oe_n;
    wire [9:0]  td_o;
    wire [9:0]  td_oe_n;
    wire [15:0] lcd_o;
    wire [15:0] lcd_oe_n;
    wire [7:0]  byte_o;
    wire [7:0]  byte_oe_n;
    wire [3:0]  clav_o;
    wire [3:0]  clav_oe_n;

    genvar g;
    generate
        for (g = 0; g < 10; g = g + 1) begin : g_tx
            localparam integer B = (g >= 4) ? `TX_HI_BASE + (9 - g) * `TX_CELLS
                                            : `TX_LO_BASE + (3 - g) * `TX_CELLS;
            assign fp_o[g]    = bs_drive ? upd_reg[B + 1] : CORE_TX_FRAME_PULSE[g];
            assign fp_oe_n[g] = bs_highz | (bs_drive ? ~upd_reg[B] : CORE_TX_FRAME_PULSE_OE_N[g]); // [RL5]
            assign td_o[g]    = bs_drive ? upd_reg[B + 4] : CORE_TX_SERIAL_DATA[g];
            assign td_oe_n[g] = bs_highz | (bs_drive ? ~upd_reg[`SHARED_CTRL] : CORE_OUTPUT_OE_N); // [RL7]
        end
        for (g = 0; g < 16; g = g + 1) begin : g_lcd
            assign lcd_o[g]    = bs_drive ? upd_reg[`LCD_BASE + 15 - g] : CORE_DELINEATION_LOST[g];
            assign lcd_oe_n[g] = bs_highz | (bs_drive ? ~upd_reg[`SHARED_CTRL] : CORE_OUTPUT_OE_N); // [RL9]
        end
        for (g = 0; g < 8; g = g + 1) begin : g_byte
            localparam integer B = (g == 7) ? `CB_BYTE7_CELL : `CB_BYTE_BASE + g;
            assign byte_o[g]    = bs_drive ? upd_reg[B] : CORE_CELLBUS_BYTE[g];
            assign byte_oe_n[g] = bs_highz | (bs_drive ? ~upd_reg[`CB_BYTE_CTRL] : CORE_OUTPUT_OE_N); // [RL12]
        end
        for (g = 0; g < 4; g = g + 1) begin : g_clav
            localparam integer B = (g == 3) ? `CB_CLAV3_CELL : (g == 2) ? `CB_CLAV2_CELL :
                                   (g == 1) ? `CB_CLAV1_CELL : `CB_CLAV0_CELL;
            localparam integer K = (g == 0) ? `CB_CLAV0_CTRL : `CB_CLAV_CTRL;
            assign clav_o[g]    = bs_drive ? upd_reg[B] : CORE_CELLBUS_CELL_AVAIL[g];
            assign clav_oe_n[g] = bs_highz | (bs_drive ? ~upd_reg[K] : CORE_OUTPUT_OE_N); // [RL11]
        end
    endgenerate

    wire par_o  = bs_drive ? upd_reg[`CB_PARITY_CELL] : CORE_CELLBUS_PARITY;
    wire soc_o  = bs_drive ? upd_reg[`CB_SOC_CELL] : CORE_CELLBUS_START_OF_CELL;
    wire ps_oen = bs_highz | (bs_drive ? ~upd_reg[`CB_PS_CTRL] : CORE_OUTPUT_OE_N); // [RL10]

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            TX_FRAME_PULSE_PORT_OUT       <= 10'h000;
            TX_FRAME_PULSE_PORT_OE_N      <= 10'h3FF;
            TX_SERIAL_DATA_PORT_OUT       <= 10'h000;
            TX_SERIAL_DATA_PORT_OE_N      <= 10'h3FF;
            RX_DELINEATION_LOST_PORT_OUT  <= 16'h0000;
            RX_DELINEATION_LOST_PORT_OE_N <= 16'hFFFF;
            CELLBUS_RX_PARITY_OUT         <= 1'b0;
            CELLBUS_RX_PARITY_OE_N        <= 1'b1;
            CELLBUS_RX_START_OF_CELL_OUT  <= 1'b0;
            CELLBUS_RX_START_OF_CELL_OE_N <= 1'b1;
            CELLBUS_RX_CELL_AVAIL_OUT     <= 4'h0;
            CELLBUS_RX_CELL_AVAIL_OE_N    <= 4'hF;
            CELLBUS_RX_BYTE_OUT           <= 8'h00;
            CELLBUS_RX_BYTE_OE_N          <= 8'hFF;
        end else begin
            TX_FRAME_PULSE_PORT_OUT       <= fp_o;
            TX_FRAME_PULSE_PORT_OE_N      <= fp_oe_n;
            TX_SERIAL_DATA_PORT_OUT       <= td_o;
            TX_SERIAL_DATA_PORT_OE_N      <= td_oe_n;
            RX_DELINEATION_LOST_PORT_OUT  <= lcd_o;
            RX_DELINEATION_LOST_PORT_OE_N <= lcd_oe_n;
            CELLBUS_RX_PARITY_OUT         <= par_o;
            CELLBUS_RX_PARITY_OE_N        <= ps_oen;
            CELLBUS_RX_START_OF_CELL_OUT  <= soc_o;
            CELLBUS_RX_START_OF_CELL_OE_N <= ps_oen;
            CELLBUS_RX_CELL_AVAIL_OUT     <= clav_o;
            CELLBUS_RX_CELL_AVAIL_OE_N    <= clav_oe_n;
            CELLBUS_RX_BYTE_OUT           <= byte_o;
            CELLBUS_RX_BYTE_OE_N          <= byte_oe_n;
        end
    end

endmodule // boundary_scan_test_registers

`default_nettype wire

/* hdl/bscan_consts.vh */
`ifndef BSCAN_CONSTS_VH
`define BSCAN_CONSTS_VH

// ==========================================================
// boundary chain layout
`define BSR_LEN         162
`define TX_HI_BASE      0
`define TX_LO_BASE      122
`define TX_CELLS        5
`define RX_BASE         30
`define RX_CELLS        3
`define LCD_BASE        54
`define CB_PARITY_CELL  70
`define CB_CLAV3_CELL   71
`define CB_CLAV2_CELL   72
`define CB_CLAV_CTRL    73
`define CB_CLAV1_CELL   74
`define CB_CLAV0_CTRL   75
`define CB_CLAV0_CELL   76
`define CB_PS_CTRL      77
`define CB_SOC_CELL     78
`define CB_BYTE_BASE    79
`define CB_BYTE_CTRL    86
`define CB_BYTE7_CELL   87
`define AUX_BASE        88
`define AUX_LEN         34
`define SHARED_CTRL     161

// ==========================================================
// instruction codes
`define INS_EXTEST      3'h0
`define INS_IDCODE      3'h1
`define INS_SAMPLE      3'h2
`define INS_CLAMP       3'h3
`define INS_HIGHZ       3'h4
`define INS_BYPASS      3'h7

// ==========================================================
// identification value; field values are arbitrary
`define ID_VERSION      4'h1
`define ID_PART         16'hB5C3
`define ID_MAKER        11'h2D6
`define ID_VALUE        {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1}

`endif

/* testbench/bscan_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bscan_consts.vh"
// ==========================================
// pin relations at the block boundary
module bscan_regs_monitor (
    // system
    input wire logic        SYS_CLK,
    input wire logic        SYS_RST,
    // test link
    input wire logic        TEST_UPDATE_DR,
    input wire logic        TEST_LOGIC_RESET,
    input wire logic [2:0]  TEST_INSTR,
    input wire logic [31:0] TEST_ID_LATCH,
    // pins
    input wire logic [9:0]  TX_SERIAL_DATA_PORT_OUT,
    input wire logic [9:0]  TX_SERIAL_DATA_PORT_OE_N,
    input wire logic [15:0] RX_DELINEATION_LOST_PORT_OE_N,
    input wire logic        CELLBUS_RX_PARITY_OE_N,
    input wire logic        CELLBUS_RX_START_OF_CELL_OE_N,
    input wire logic [3:0]  CELLBUS_RX_CELL_AVAIL_OE_N,
    input wire logic [7:0]  CELLBUS_RX_BYTE_OE_N,
    input wire logic [9:0]  CORE_TX_SERIAL_DATA
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    sequence s_ext; (TEST_INSTR == `INS_EXTEST)[*5]; endsequence
    property p_id_rst; $fell(SYS_RST) |-> TEST_ID_LATCH == `ID_VALUE; endproperty
    a_id_rst: assert property (p_id_rst) else $error("id latch wrong after reset");
    property p_id_hold; (!TEST_UPDATE_DR)[*8] |-> $stable(TEST_ID_LATCH); endproperty
    a_id_hold: assert property (p_id_hold) else $error("id latch moved without update");
    property p_core; (TEST_INSTR == `INS_SAMPLE)[*5] |-> TX_SERIAL_DATA_PORT_OUT == $past(CORE_TX_SERIAL_DATA);
    endproperty
    a_core: assert property (p_core) else $error("sample disturbed data pins");
    property p_tx_en; s_ext |-> TX_SERIAL_DATA_PORT_OE_N == {10{RX_DELINEATION_LOST_PORT_OE_N[0]}}; endproperty
    a_tx_en: assert property (p_tx_en) else $error("data enables not shared");
    property p_lcd_en; s_ext |-> RX_DELINEATION_LOST_PORT_OE_N == {16{TX_SERIAL_DATA_PORT_OE_N[9]}}; endproperty
    a_lcd_en: assert property (p_lcd_en) else $error("delineation enables not shared");
    property p_clav_en; s_ext |-> CELLBUS_RX_CELL_AVAIL_OE_N[3:1] inside {3'h0, 3'h7}; endproperty
    a_clav_en: assert property (p_clav_en) else $error("cell avail enables split");
    property p_byte_en; s_ext |-> CELLBUS_RX_BYTE_OE_N inside {8'h00, 8'hFF}; endproperty
    a_byte_en: assert property (p_byte_en) else $error("byte enables split");
    property p_ps_en; s_ext |-> CELLBUS_RX_PARITY_OE_N == CELLBUS_RX_START_OF_CELL_OE_N; endproperty
    a_ps_en: assert property (p_ps_en) else $error("parity and start enables differ");
    property p_latched;
        (TEST_INSTR == `INS_EXTEST && !TEST_UPDATE_DR && !TEST_LOGIC_RESET)[*8] |-> $stable(TX_SERIAL_DATA_PORT_OUT);
    endproperty
    a_latched: assert property (p_latched) else $error("pins moved without update");
    c_ext_upd: cover property (TEST_UPDATE_DR && TEST_INSTR == `INS_EXTEST);
    c_hiz: cover property (TEST_INSTR == `INS_HIGHZ);
    c_id: cover property ($changed(TEST_ID_LATCH));
endmodule // bscan_regs_monitor
bind boundary_scan_test_registers bscan_regs_monitor mon (.*);
`default_nettype wire

/* testbench/tap_tester_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bscan_consts.vh"
// ==========================================
// external tester: test clock still between frames
module tap_tester_model (
    // system
    input  wire logic       sys_clk,
    input  wire logic       serial_out,
    // test link toward the block
    output var  logic       test_clock,
    output var  logic       serial_in,
    output var  logic       logic_reset,
    output var  logic       capture_dr,
    output var  logic       shift_dr,
    output var  logic       update_dr,
    output var  logic [2:0] instr
);
    initial begin
        {test_clock, serial_in, logic_reset, capture_dr, shift_dr, update_dr} = 6'h00;
        instr = `INS_BYPASS;
    end
    // one test clock period of 8 sys cycles, clock low between periods
    task automatic tick(input logic cap, sh, up, tdi, output logic tdo);
        @(negedge sys_clk);
        {capture_dr, shift_dr, update_dr, serial_in} = {cap, sh, up, tdi};
        repeat (3) @(negedge sys_clk);
        test_clock = 1'b1;
        repeat (3) @(negedge sys_clk);
        test_clock = 1'b0;
        @(negedge sys_clk);
        tdo = serial_out;
        serial_in = ~tdi;
    endtask
    // capture, n shifts, update, idle
    task automatic scan(input int n, input logic [161:0] din, output logic [162:0] dout);
        logic b;
        dout = 163'h0;
        tick(1'b1, 1'b0, 1'b0, 1'b0, b);
        dout[0] = b;
        for (int j = 0; j < n; j++) begin
            tick(1'b0, 1'b1, 1'b0, din[j], b);
            dout[j + 1] = b;
        end
        tick(1'b0, 1'b0, 1'b1, 1'b0, b);
        tick(1'b0, 1'b0, 1'b0, 1'b0, b);
    endtask
    task automatic set_mode(input logic [2:0] code);
        @(negedge sys_clk);
        instr = code;
        repeat (8) @(negedge sys_clk);
    endtask
    // one test clock period in test-logic-reset, serial out read inside it
    task automatic tap_reset(output logic tdo);
        @(negedge sys_clk);
        logic_reset = 1'b1;
        tick(1'b0, 1'b0, 1'b0, 1'b0, tdo);
        logic_reset = 1'b0;
        repeat (8) @(negedge sys_clk);
    endtask
endmodule // tap_tester_model
`default_nettype wire

/* testbench/boundary_scan_test_registers_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bscan_consts.vh"
module boundary_scan_test_registers_test;
    // ==========================================
    // signals
    logic        SYS_CLK, SYS_RST, TEST_CLOCK, TEST_SERIAL_IN, TEST_LOGIC_RESET, TEST_CAPTURE_DR;
    logic        TEST_SHIFT_DR, TEST_UPDATE_DR, TEST_SERIAL_OUT;
    logic [2:0]  TEST_INSTR;
    logic [31:0] TEST_ID_LATCH;
    logic [9:0]  TX_FRAME_PULSE_PORT_IN, TX_FRAME_PULSE_PORT_OUT, TX_FRAME_PULSE_PORT_OE_N, TX_LINE_CLOCK_PORT;
    logic [9:0]  TX_SERIAL_DATA_PORT_OUT, TX_SERIAL_DATA_PORT_OE_N, CORE_TX_FRAME_PULSE, CORE_TX_FRAME_PULSE_OE_N;
    logic [9:0]  CORE_TX_SERIAL_DATA;
    logic [7:0]  RX_FRAME_PULSE_PORT, RX_LINE_CLOCK_PORT, RX_SERIAL_DATA_PORT;
    logic [7:0]  CELLBUS_RX_BYTE_OUT, CELLBUS_RX_BYTE_OE_N, CORE_CELLBUS_BYTE;
    logic [15:0] RX_DELINEATION_LOST_PORT_OUT, RX_DELINEATION_LOST_PORT_OE_N, CORE_DELINEATION_LOST;
    logic        CELLBUS_RX_PARITY_OUT, CELLBUS_RX_PARITY_OE_N, CELLBUS_RX_START_OF_CELL_OUT;
    logic        CELLBUS_RX_START_OF_CELL_OE_N, CORE_CELLBUS_PARITY, CORE_CELLBUS_START_OF_CELL, CORE_OUTPUT_OE_N;
    logic [3:0]  CELLBUS_RX_CELL_AVAIL_OUT, CELLBUS_RX_CELL_AVAIL_OE_N, CORE_CELLBUS_CELL_AVAIL;
    logic [33:0] CELLBUS_AUX_IN;
    logic [60:0] core_cnt = 61'h0;
    logic [162:0] dout;
    logic [161:0] vec;
    int          n_fail, total_checks;
    boundary_scan_test_registers dut (.*);
    tap_tester_model tester (.sys_clk(SYS_CLK), .serial_out(TEST_SERIAL_OUT), .test_clock(TEST_CLOCK),
        .serial_in(TEST_SERIAL_IN), .logic_reset(TEST_LOGIC_RESET), .capture_dr(TEST_CAPTURE_DR),
        .shift_dr(TEST_SHIFT_DR), .update_dr(TEST_UPDATE_DR), .instr(TEST_INSTR));
    // core side keeps changing so pins cannot hide a stale value
    assign {CORE_TX_FRAME_PULSE, CORE_TX_FRAME_PULSE_OE_N, CORE_TX_SERIAL_DATA, CORE_DELINEATION_LOST,
            CORE_CELLBUS_PARITY, CORE_CELLBUS_START_OF_CELL, CORE_CELLBUS_CELL_AVAIL, CORE_CELLBUS_BYTE,
            CORE_OUTPUT_OE_N} = core_cnt;
    initial begin
        SYS_CLK = 1'b0;
        forever #20 SYS_CLK = ~SYS_CLK;
    end
    always @(negedge SYS_CLK) core_cnt <= core_cnt + 61'h1357_9BDF_0246_8ACF;
    // ==========================================
    // helpers
    task automatic chk(input logic [162:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic int tx_base(input int port);
        return (port >= 8) ? 5 * (13 - port) : 122 + 5 * (7 - port);
    endfunction
    // ==========================================
    // scenarios
    task automatic t_idcode();
        tester.set_mode(`INS_IDCODE);
        tester.scan(32, 162'hA5C30F69, dout);
        chk(dout[31:0], `ID_VALUE, "id shifted out");
        chk(dout[0], 1'b1, "id lsb");
        chk(dout[32], 1'b1, "shifted-in bit reached output");
        chk(TEST_ID_LATCH, 32'hA5C30F69, "id latch");
    endtask
    task automatic t_bypass(input logic [2:0] code);
        tester.set_mode(code);
        tester.scan(8, 162'hB2, dout);
        chk(dout[8:1], 8'hB2, "one-stage path");
    endtask
    task automatic t_sample(input logic [161:0] v);
        int b;
        @(negedge SYS_CLK);
        {TX_FRAME_PULSE_PORT_IN, TX_LINE_CLOCK_PORT, RX_FRAME_PULSE_PORT, RX_LINE_CLOCK_PORT,
         RX_SERIAL_DATA_PORT} = v[43:0];
        CELLBUS_AUX_IN = v[77:44];
        tester.set_mode(`INS_SAMPLE);
        tester.scan(162, v, dout);
        for (int p = 8; p < 16; p++) begin
            b = 30 + 3 * (15 - p);
            chk(dout[b +: 3], {v[p - 8], v[p], v[p + 8]}, "rx observe");
        end
        for (int i = 0; i < 10; i++) begin
            b = tx_base(i + 4);
            chk(dout[b + 2 +: 2], {v[24 + i], v[34 + i]}, "tx observe");
        end
        chk(dout[121:88], v[77:44], "aux observe");
    endtask
    task automatic t_tlr(input logic [161:0] v);
        logic b;
        tester.tap_reset(b);
        chk(b, 1'b1, "id not selected in test-logic-reset");
        chk(TEST_SERIAL_OUT, v[0], "chain not reselected after reset");
    endtask
    task automatic t_drive(input logic [2:0] code, input logic [161:0] v);
        int b;
        tester.set_mode(code);
        for (int i = 0; i < 10; i++) begin
            b = tx_base(i + 4);
            chk({TX_FRAME_PULSE_PORT_OE_N[i], TX_FRAME_PULSE_PORT_OUT[i]}, {~v[b], v[b + 1]}, "frame");
            chk({TX_SERIAL_DATA_PORT_OE_N[i], TX_SERIAL_DATA_PORT_OUT[i]}, {~v[161], v[b + 4]}, "data");
        end
        for (int p = 0; p < 16; p++)
            chk({RX_DELINEATION_LOST_PORT_OE_N[p], RX_DELINEATION_LOST_PORT_OUT[p]}, {~v[161], v[69 - p]}, "lcd");
        chk({CELLBUS_RX_PARITY_OE_N, CELLBUS_RX_PARITY_OUT, CELLBUS_RX_START_OF_CELL_OE_N,
             CELLBUS_RX_START_OF_CELL_OUT}, {~v[77], v[70], ~v[77], v[78]}, "parity soc");
        chk({CELLBUS_RX_CELL_AVAIL_OE_N, CELLBUS_RX_CELL_AVAIL_OUT},
            {{3{~v[73]}}, ~v[75], v[71], v[72], v[74], v[76]}, "cell avail");
        chk({CELLBUS_RX_BYTE_OE_N, CELLBUS_RX_BYTE_OUT}, {{8{~v[86]}}, v[87], v[85:79]}, "byte");
    endtask
    // ==========================================
    // main sequence
    initial begin
        n_fail = 0;
        total_checks = 0;
        vec = 162'h2_F1A3_9D3C_5A0F_E184_76B2_C3D5_1E8F_A96C_07B4_D25E;
        {TX_FRAME_PULSE_PORT_IN, TX_LINE_CLOCK_PORT, RX_FRAME_PULSE_PORT, RX_LINE_CLOCK_PORT,
         RX_SERIAL_DATA_PORT} = 44'h0;
        CELLBUS_AUX_IN = 34'h0;
        SYS_RST = 1'b1;
        repeat (3) @(negedge SYS_CLK);
        SYS_RST = 1'b0;
        repeat (4) @(negedge SYS_CLK);
        chk(TEST_ID_LATCH, `ID_VALUE, "id latch after reset");
        t_idcode();
        t_sample(vec);
        t_drive(`INS_EXTEST, vec);
        t_tlr(vec);
        t_drive(`INS_CLAMP, vec);
        t_sample(~vec);
        t_drive(`INS_EXTEST, ~vec);
        t_bypass(`INS_BYPASS);
        t_bypass(`INS_CLAMP);
        t_bypass(`INS_HIGHZ);
        chk(&{TX_FRAME_PULSE_PORT_OE_N, TX_SERIAL_DATA_PORT_OE_N, RX_DELINEATION_LOST_PORT_OE_N,
              CELLBUS_RX_BYTE_OE_N, CELLBUS_RX_CELL_AVAIL_OE_N, CELLBUS_RX_PARITY_OE_N,
              CELLBUS_RX_START_OF_CELL_OE_N}, 1'b1, "high-z");
        final_report();
    end
    initial begin
        repeat (40000) @(posedge SYS_CLK);
        n_fail++;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report();
    end
endmodule // boundary_scan_test_registers_test
`default_nettype wire
